// ==== hdl/eoh_top.sv ====
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module eoh_top (
  // Clock, reset, enable
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               ce,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output var  logic [31:0]        hrdata_ff,
  output var  logic               hreadyout_ff,
  output var  logic               hresp_ff,
  // Receive overhead events
  input  wire logic               sa6_word_vld,
  input  wire logic [3:0]         sa6_word,
  input  wire logic               e_bits_vld,
  input  wire logic [1:0]         e_bits,
  input  wire logic               rx_crc_mf_sync_lost,
  input  wire logic               rx_crc4_err,
  input  wire logic               cont_alarm_error_state,
  input  wire logic               cont_far_error_state,
  input  wire logic               link_id_state,
  // Transmit stream
  input  wire logic               tx_in_vld,
  input  wire eoh_pkg::eoh_slot_s tx_in,
  output var  logic               tx_out_vld_ff,
  output var  eoh_pkg::eoh_slot_s tx_out_ff,
  // Generation status and interrupt
  output var  logic               gen_basic_ff,
  output var  logic               gen_crc_mf_ff,
  output var  logic               gen_mod_crc_ff,
  output var  logic               gen_sig_mf_ff,
  output var  logic               irq_ff
);

  // --------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------
  eoh_pkg::eoh_bus_e bus_st_ff;
  logic [7:0]        adr_ff;
  logic              hit_ff;
  logic              wr_ff;
  logic [7:0]        irq_en_ff;
  logic [7:0]        flg_ff;
  logic [7:0]        mode_ff;
  logic [7:0]        intl_ff;
  logic [7:0]        nat_en_ff;
  logic [7:0]        extra_ff;
  logic [7:0]        cw_ff [5];
  logic [2:0]        state_prev_ff;
  logic [1:0]        e_pend_ff;
  localparam int     ADDR_HI = 9;

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire logic       acc      = hsel & htrans[1] & hready;
  wire logic       dphase   = (bus_st_ff == eoh_pkg::BUS_DATA);
  wire logic       wr_any   = dphase & wr_ff & hit_ff & ce;
  wire logic       wr_en    = wr_any & (adr_ff == eoh_pkg::IDX_OH_IRQ_EN);
  wire logic       wr_flags = wr_any & (adr_ff == eoh_pkg::IDX_OH_FLAGS);
  wire logic       wr_mode  = wr_any & (adr_ff == eoh_pkg::IDX_TX_MODE);
  wire logic       wr_intl  = wr_any & (adr_ff == eoh_pkg::IDX_TX_INTL);
  wire logic       wr_nat   = wr_any & (adr_ff == eoh_pkg::IDX_TX_NAT_EN);
  wire logic       wr_extra = wr_any & (adr_ff == eoh_pkg::IDX_TX_EXTRA);
  wire logic       cw_sel   = (adr_ff >= eoh_pkg::IDX_SA4_CW) &&
                              (adr_ff <= eoh_pkg::IDX_SA8_CW);
  wire logic [7:0] cw_idx   = adr_ff - eoh_pkg::IDX_SA4_CW;
  wire logic [2:0] state_in = {cont_alarm_error_state,
                               cont_far_error_state, link_id_state};

  // Read selection; unmapped words read as zero
  wire logic [7:0] rd_val =
    !hit_ff ? eoh_pkg::RST_ZERO :
    (adr_ff == eoh_pkg::IDX_OH_STATE)  ? {5'h00, state_in} :
    (adr_ff == eoh_pkg::IDX_OH_IRQ_EN) ? irq_en_ff :
    (adr_ff == eoh_pkg::IDX_OH_FLAGS)  ? flg_ff :
    (adr_ff == eoh_pkg::IDX_TX_MODE)   ? mode_ff :
    (adr_ff == eoh_pkg::IDX_TX_INTL)   ? intl_ff :
    (adr_ff == eoh_pkg::IDX_TX_NAT_EN) ? nat_en_ff :
    (adr_ff == eoh_pkg::IDX_TX_EXTRA)  ? extra_ff :
    cw_sel ? cw_ff[cw_idx[2:0]] : eoh_pkg::RST_ZERO;

  // One wait state so that read data can leave a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_ff    <= eoh_pkg::BUS_IDLE;
      adr_ff       <= eoh_pkg::RST_ZERO;
      hit_ff       <= 1'b0;
      wr_ff        <= 1'b0;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else if (ce) begin
      if (dphase) begin
        bus_st_ff    <= eoh_pkg::BUS_IDLE;
        hreadyout_ff <= 1'b1;
        hrdata_ff    <= {24'h00_0000, rd_val};
      end else if (acc) begin
        bus_st_ff    <= eoh_pkg::BUS_DATA;
        hreadyout_ff <= 1'b0;
        adr_ff       <= haddr[ADDR_HI:eoh_pkg::ADDR_LSB];
        hit_ff       <= (haddr[31:ADDR_HI+1] == 22'h00_0000);
        wr_ff        <= hwrite;
      end
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_ff <= eoh_pkg::RST_ZERO;
      mode_ff   <= eoh_pkg::RST_MODE;
      intl_ff   <= eoh_pkg::RST_INTL;
      nat_en_ff <= eoh_pkg::RST_ZERO;
      extra_ff  <= eoh_pkg::RST_EXTRA;
    end else begin
      if (wr_en)    irq_en_ff <= hwdata[7:0] & eoh_pkg::MASK_FLAGS;
      if (wr_mode)  mode_ff   <= hwdata[7:0] & eoh_pkg::MASK_MODE;
      if (wr_intl)  intl_ff   <= hwdata[7:0] & eoh_pkg::MASK_INTL;
      if (wr_nat)   nat_en_ff <= hwdata[7:0] & eoh_pkg::MASK_NAT;
      if (wr_extra) extra_ff  <= hwdata[7:0] & eoh_pkg::MASK_EXTRA;
    end
  end

  // Five national bit codewords, Sa4 first
  genvar gk;
  generate
    for (gk = 0; gk < 5; gk++) begin : g_cw
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cw_ff[gk] <= eoh_pkg::RST_SA_CW;
        end else if (wr_any && cw_sel && cw_idx == gk) begin
          cw_ff[gk] <= hwdata[7:0] & eoh_pkg::MASK_CW;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Overhead events and sticky flags
  // --------------------------------------------------------------------
  wire logic nt_crc_set = sa6_word_vld &
    ((sa6_word == eoh_pkg::SA6_NT_CRC) ||
     (sa6_word == eoh_pkg::SA6_NT_BOTH));
  wire logic nt_far_set = sa6_word_vld &
    ((sa6_word == eoh_pkg::SA6_NT_FAR) ||
     (sa6_word == eoh_pkg::SA6_NT_BOTH));
  // FEBE detection is suspended out of CRC multiframe sync
  wire logic far_set = e_bits_vld & !rx_crc_mf_sync_lost &
                       (e_bits != 2'b11);
  wire logic [2:0] chg = state_in ^ state_prev_ff;
  wire logic [7:0] flg_set = {2'b00, nt_crc_set, nt_far_set, far_set, chg};
  wire logic [7:0] flg_clr = wr_flags ? hwdata[7:0] : 8'h00;
  // Set wins over a clear landing in the same cycle
  wire logic [7:0] nxt_flg = ((flg_ff & ~flg_clr) | flg_set) &
                             eoh_pkg::MASK_FLAGS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flg_ff        <= eoh_pkg::RST_ZERO;
      state_prev_ff <= 3'b000;
      irq_ff        <= 1'b0;
    end else if (ce) begin
      flg_ff        <= nxt_flg;
      state_prev_ff <= state_in;
      irq_ff        <= |(flg_ff & irq_en_ff);
    end
  end

  // --------------------------------------------------------------------
  // Frame generation mode
  // --------------------------------------------------------------------
  wire logic gen_on  = !mode_ff[eoh_pkg::MODE_GEN_OFF];
  wire logic crc_on  = gen_on & mode_ff[eoh_pkg::MODE_CRC];
  wire logic sig_on  = gen_on & mode_ff[eoh_pkg::MODE_SIG];
  wire logic mcrc_on = crc_on & mode_ff[eoh_pkg::MODE_MODCRC];
  wire logic e_off   = mode_ff[eoh_pkg::MODE_EAUTO_OFF];
  wire logic i_off   = mode_ff[eoh_pkg::MODE_INTL_OFF];
  wire logic x_off   = mode_ff[eoh_pkg::MODE_EXTRA_OFF];

  // --------------------------------------------------------------------
  // Slot position decode
  // --------------------------------------------------------------------
  wire logic is_ts0 = (tx_in.ts == eoh_pkg::TS_FRAMING);
  wire logic is_fas  = is_ts0 & !tx_in.frame[0];
  wire logic is_nfas = is_ts0 & tx_in.frame[0];
  wire logic is_e1   = is_ts0 & (tx_in.frame == eoh_pkg::FRM_E1);
  wire logic is_e2   = is_ts0 & (tx_in.frame == eoh_pkg::FRM_E2);
  wire logic is_x    = (tx_in.ts == eoh_pkg::TS_SIGNAL) &
                       (tx_in.frame == eoh_pkg::FRM_MF_START);

  // E bit source: auto zero, international values, or untouched
  wire logic e_auto = !e_off & !rx_crc_mf_sync_lost;
  wire logic e_si   = (!e_off & rx_crc_mf_sync_lost) |
                      (e_off & !i_off);
  wire logic e_slot = crc_on & tx_in_vld & (is_e1 | is_e2);
  wire logic e_zero = e_slot & e_auto & (e_pend_ff != 2'b00);
  wire logic e_inc  = rx_crc4_err & e_auto & crc_on & (e_pend_ff != 2'b11);
  wire logic [1:0] nxt_e_pend = e_pend_ff + {1'b0, e_inc} - {1'b0, e_zero};
  wire logic e_val  = e_auto ? !e_zero :
                      is_e1 ? intl_ff[eoh_pkg::INTL_FAS] :
                      intl_ff[eoh_pkg::INTL_NFAS];

  // Basic frame international bit
  wire logic i_basic = gen_on & !crc_on & !i_off;
  wire logic i_val   = is_fas ? intl_ff[eoh_pkg::INTL_FAS] :
                       intl_ff[eoh_pkg::INTL_NFAS];

  // National bits: Sa4 sits at data[4] and Sa8 at data[0]
  logic [4:0] sa_hit;
  logic [4:0] sa_val;
  generate
    for (gk = 0; gk < 5; gk++) begin : g_sa
      // Bit 1 only in basic mode, walk all four bits per sub multiframe
      assign sa_val[4-gk] = crc_on ? cw_ff[gk][~tx_in.frame[2:1]] :
                            cw_ff[gk][3];
      assign sa_hit[4-gk] = gen_on & is_nfas &
                            nat_en_ff[4-gk];
    end
  endgenerate

  // Compose the outgoing byte
  logic [7:0] nxt_data;
  always_comb begin
    nxt_data = tx_in.data;
    if (gen_on) begin
      if (i_basic && is_ts0) begin
        nxt_data[7] = i_val;
      end
      if (e_slot && (e_auto || e_si)) begin
        nxt_data[7] = e_val;
      end
      nxt_data[4:0] = (sa_hit & sa_val) | (~sa_hit & nxt_data[4:0]);
      if (sig_on && !x_off && is_x) begin
        nxt_data[3] = extra_ff[3];
        nxt_data[1] = extra_ff[1];
        nxt_data[0] = extra_ff[0];
      end
    end
  end

  // Transmit pipeline and generation status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_out_vld_ff  <= 1'b0;
      tx_out_ff      <= '0;
      e_pend_ff      <= 2'b00;
      gen_basic_ff   <= 1'b0;
      gen_crc_mf_ff  <= 1'b0;
      gen_mod_crc_ff <= 1'b0;
      gen_sig_mf_ff  <= 1'b0;
    end else if (ce) begin
      tx_out_vld_ff  <= tx_in_vld;
      if (tx_in_vld) begin
        tx_out_ff <= '{frame: tx_in.frame, ts: tx_in.ts, data: nxt_data};
      end
      e_pend_ff      <= nxt_e_pend;
      gen_basic_ff   <= gen_on;
      gen_crc_mf_ff  <= crc_on;
      gen_mod_crc_ff <= mcrc_on;
      gen_sig_mf_ff  <= sig_on;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_IRQ_MASKED: assert property (
    ce && ((flg_ff & irq_en_ff) == 8'h00) |=> !irq_ff)
    else $error("irq with no enabled flag");
  AST_IRQ_HOLD: assert property (
    ce && |(flg_ff & irq_en_ff) && !wr_flags && !wr_en ##1 ce |=> irq_ff)
    else $error("irq dropped while enabled flag set");
  AST_NT_CRC: assert property (
    ce && sa6_word_vld && sa6_word == 4'h2 |=> flg_ff[5])
    else $error("nt crc flag not set");
  AST_NT_FAR: assert property (
    ce && sa6_word_vld && sa6_word == 4'h1 && !wr_flags
    |=> flg_ff[4] && !$changed(flg_ff[5]))
    else $error("nt far flag wrong");
  AST_FAR_SUSP: assert property (
    ce && e_bits_vld && rx_crc_mf_sync_lost && !flg_ff[3] |=> !flg_ff[3])
    else $error("far flag set out of sync");
  AST_LINK_CHG: assert property (
    ce && $changed(link_id_state) && $past(ce) |-> ##1 flg_ff[0])
    else $error("link change missed");
  AST_ALARM_CHG: assert property (
    ce && $past(ce) && $changed(cont_alarm_error_state) |=> flg_ff[2])
    else $error("alarm change missed");
  AST_CFAR_CHG: assert property (
    ce && $past(ce) && $changed(cont_far_error_state) |=> flg_ff[1])
    else $error("far change missed");
  AST_FAR_SET: assert property (
    ce && e_bits_vld && !rx_crc_mf_sync_lost && e_bits != 2'b11
    |=> flg_ff[3])
    else $error("far flag not set");
  AST_W1C: assert property (
    wr_flags && hwdata[3] && !far_set |=> !flg_ff[3])
    else $error("flag not cleared");
  AST_EXTRA: assert property (
    ce && tx_in_vld && sig_on && !x_off && is_x
    |=> tx_out_ff.data[1:0] == $past(extra_ff[1:0]))
    else $error("extra bits not inserted");
  AST_INTL_FAS: assert property (
    ce && tx_in_vld && i_basic && is_fas
    |=> tx_out_ff.data[7] == $past(intl_ff[0]))
    else $error("fas international bit wrong");
  AST_INTL_NFAS: assert property (
    ce && tx_in_vld && i_basic && is_nfas
    |=> tx_out_ff.data[7] == $past(intl_ff[1]))
    else $error("nfas international bit wrong");
  AST_E_ZERO: assert property (
    ce && e_slot && e_auto && e_pend_ff != 2'b00
    |=> !tx_out_ff.data[7])
    else $error("pending error not sent as zero");
  AST_E_SI: assert property (
    ce && e_slot && e_si && is_e1
    |=> tx_out_ff.data[7] == $past(intl_ff[0]))
    else $error("E1 bit not from international value");
  AST_E_KEEP: assert property (
    ce && e_slot && e_off && i_off
    |=> tx_out_ff.data[7] == $past(tx_in.data[7]))
    else $error("E bit altered");
  AST_GEN_OFF: assert property (
    ce && tx_in_vld && !gen_on |=> tx_out_ff.data == $past(tx_in.data))
    else $error("byte altered with generation off");
  AST_SIG_GEN: assert property (
    ce && !mode_ff[0] && mode_ff[2] |=> gen_sig_mf_ff)
    else $error("signaling multiframe not generated");
  AST_NAT4: assert property (
    ce && tx_in_vld && is_nfas && gen_on && !crc_on && nat_en_ff[4]
    |=> tx_out_ff.data[4] == $past(cw_ff[0][3]))
    else $error("national bit 4 not replaced");
  AST_NAT8: assert property (
    ce && tx_in_vld && is_nfas && gen_on && !crc_on && nat_en_ff[0]
    |=> tx_out_ff.data[0] == $past(cw_ff[4][3]))
    else $error("national bit 8 not replaced");
  AST_NAT_KEEP: assert property (
    ce && tx_in_vld && is_nfas && nat_en_ff == 8'h00
    |=> tx_out_ff.data[4:0] == $past(tx_in.data[4:0]))
    else $error("national bits altered while disabled");
  AST_MOD_CRC: assert property (
    gen_mod_crc_ff |-> gen_crc_mf_ff)
    else $error("modified crc without crc multiframe");

  COV_IRQ: cover property (ce && !irq_ff ##1 irq_ff);
  COV_E_ZERO: cover property (ce && e_zero);
  COV_EXTRA: cover property (ce && tx_in_vld && sig_on && !x_off && is_x);
  COV_E_SI: cover property (ce && e_slot && e_si);
  COV_NAT: cover property (ce && tx_in_vld && |sa_hit);

endmodule // eoh_top
`default_nettype wire

// ==== inc/eoh_pkg.sv ====
// Functional notes
// - Each of the overhead enables lets its own flag drive the interrupt output.
// - Received Sa6 codeword 0010 or 0011 sets the NT CRC error flag.
// - Received Sa6 codeword 0001 or 0011 sets the NT far error flag.
// - Zero E bit sets far error flag only while CRC multiframe sync held.
// - Any toggle of the three status inputs sets its change flag.
// - Writing one to a flag clears it; software acknowledges this way.
// - Signaling multiframe, extra bits on: TS16 frame 0 bits 5,7,8 replaced.
// - Basic frame, international bits on: FAS and NFAS bit 1 replaced.
// - CRC mode, auto E on and in sync: one zero per CRC-4 error, up to three pending.
// - CRC mode, E bits take the two international values in two cases.
// - CRC mode with both E disables set leaves E bits untouched.
// - Frame generation off stops all frame and multiframe generation.
// - Generation on: signaling and CRC multiframes follow their enables.
// - Modified CRC select acts only with CRC multiframe generation on.
// - Sa4 to Sa6 replace enables overwrite national bits with codewords.
// - Sa7 and Sa8 replace enables work exactly like Sa4 to Sa6.
// - Basic only uses codeword bit 1; CRC multiframe uses all four bits.
`default_nettype none
package eoh_pkg;

  // --------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_OH_STATE  = 8'h5F;
  localparam logic [7:0] IDX_OH_IRQ_EN = 8'h60;
  localparam logic [7:0] IDX_OH_FLAGS  = 8'h61;
  localparam logic [7:0] IDX_TX_MODE   = 8'h62;
  localparam logic [7:0] IDX_TX_INTL   = 8'h63;
  localparam logic [7:0] IDX_TX_NAT_EN = 8'h64;
  localparam logic [7:0] IDX_SA4_CW    = 8'h65;
  localparam logic [7:0] IDX_SA8_CW    = 8'h69;
  localparam logic [7:0] IDX_TX_EXTRA  = 8'h6A;
  localparam int         ADDR_LSB      = 2;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int FLG_LINK       = 0;
  localparam int FLG_CONT_FAR   = 1;
  localparam int FLG_CONT_ALARM = 2;
  localparam int FLG_FAR        = 3;
  localparam int FLG_NT_FAR     = 4;
  localparam int FLG_NT_CRC     = 5;
  localparam int MODE_GEN_OFF   = 0;
  localparam int MODE_CRC       = 1;
  localparam int MODE_SIG       = 2;
  localparam int MODE_MODCRC    = 3;
  localparam int MODE_EAUTO_OFF = 4;
  localparam int MODE_INTL_OFF  = 5;
  localparam int MODE_EXTRA_OFF = 6;
  localparam int INTL_FAS       = 0;
  localparam int INTL_NFAS      = 1;

  // --------------------------------------------------------------------
  // Reset values and readback masks
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_MODE   = 8'h06;
  localparam logic [7:0] RST_INTL   = 8'h03;
  localparam logic [7:0] RST_SA_CW  = 8'h0F;
  localparam logic [7:0] RST_EXTRA  = 8'h0B;
  localparam logic [7:0] MASK_FLAGS = 8'h3F;
  localparam logic [7:0] MASK_MODE  = 8'h7F;
  localparam logic [7:0] MASK_INTL  = 8'h03;
  localparam logic [7:0] MASK_NAT   = 8'h1F;
  localparam logic [7:0] MASK_CW    = 8'h0F;
  localparam logic [7:0] MASK_EXTRA = 8'h0B;

  // --------------------------------------------------------------------
  // Codewords and frame positions
  // --------------------------------------------------------------------
  localparam logic [3:0] SA6_NT_CRC   = 4'h2;
  localparam logic [3:0] SA6_NT_BOTH  = 4'h3;
  localparam logic [3:0] SA6_NT_FAR   = 4'h1;
  localparam logic [4:0] TS_FRAMING   = 5'h00;
  localparam logic [4:0] TS_SIGNAL    = 5'h10;
  localparam logic [3:0] FRM_E1       = 4'hD;
  localparam logic [3:0] FRM_E2       = 4'hF;
  localparam logic [3:0] FRM_MF_START = 4'h0;

  // Timeslot byte with its place in the multiframe, bit 1 is data[7]
  typedef struct packed {
    logic [3:0] frame;
    logic [4:0] ts;
    logic [7:0] data;
  } eoh_slot_s;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } eoh_bus_e;

endpackage
`default_nettype wire

// ==== tb/eoh_line_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------
// Far line terminal: overhead events in, transmit slots through
// ----------
module eoh_line_model (
  // Clock and returned stream
  input  wire logic               hclk,
  input  wire eoh_pkg::eoh_slot_s tx_out_ff,
  // Receive overhead toward the block
  output var  logic               sa6_word_vld,
  output var  logic [3:0]         sa6_word,
  output var  logic               e_bits_vld,
  output var  logic [1:0]         e_bits,
  output var  logic               rx_crc4_err,
  // Transmit slots toward the block
  output var  logic               tx_in_vld,
  output var  eoh_pkg::eoh_slot_s tx_in
);
  // Quiet lines at time zero
  initial begin
    sa6_word_vld = 1'b0;
    sa6_word = 4'h0;
    e_bits_vld = 1'b0;
    e_bits = 2'h0;
    rx_crc4_err = 1'b0;
    tx_in_vld = 1'b0;
    tx_in = '0;
  end
  // One event pulse: 0 Sa6 word, 1 E bits, 2 CRC-4 error
  task automatic rx_ev(input int k, input logic [3:0] w);
    sa6_word <= w;
    e_bits <= w[1:0];
    sa6_word_vld <= (k == 0);
    e_bits_vld <= (k == 1);
    rx_crc4_err <= (k == 2);
    @(posedge hclk);
    sa6_word_vld <= 1'b0;
    e_bits_vld <= 1'b0;
    rx_crc4_err <= 1'b0;
    // Inverted data so a stale word never looks valid
    sa6_word <= ~w;
    e_bits <= ~w[1:0];
    @(posedge hclk);
  endtask
  // One slot in, its byte back one cycle later
  task automatic slot(input logic [3:0] f, input logic [4:0] t,
                      input logic [7:0] d, output logic [7:0] q);
    tx_in <= {f, t, d};
    tx_in_vld <= 1'b1;
    @(posedge hclk);
    tx_in_vld <= 1'b0;
    tx_in <= ~{f, t, d};
    @(posedge hclk);
    q = tx_out_ff.data;
  endtask
endmodule // eoh_line_model
`default_nettype wire

// ==== tb/test_e1_overhead_events_and_tx_insertion.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_e1_overhead_events_and_tx_insertion;
  // ----------
  // Signals
  // ----------
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic               hwrite = 1'b0, lost = 1'b0;
  logic [1:0]         htrans = 2'b00;
  logic [31:0]        haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [31:0]        hrdata_ff, rv;
  logic               hreadyout_ff, hresp_ff, irq_ff, tx_out_vld_ff;
  logic               gen_basic_ff, gen_crc_mf_ff, gen_mod_crc_ff;
  logic               gen_sig_mf_ff, sa6_word_vld, e_bits_vld;
  logic               rx_crc4_err, tx_in_vld;
  logic [2:0]         st = 3'h0;
  logic [3:0]         sa6_word;
  logic [1:0]         e_bits;
  logic [7:0]         q;
  eoh_pkg::eoh_slot_s tx_in, tx_out_ff;
  wire                hready = hreadyout_ff;
  int                 error_cnt = 0, tests_run = 0;
  // Clock, single slave so its ready is the bus ready
  always #25 hclk = ~hclk;
  eoh_top i_eoh_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .sa6_word_vld(sa6_word_vld), .sa6_word(sa6_word),
    .e_bits_vld(e_bits_vld), .e_bits(e_bits), .rx_crc_mf_sync_lost(lost),
    .rx_crc4_err(rx_crc4_err), .cont_alarm_error_state(st[2]),
    .cont_far_error_state(st[1]), .link_id_state(st[0]),
    .tx_in_vld(tx_in_vld), .tx_in(tx_in), .tx_out_vld_ff(tx_out_vld_ff),
    .tx_out_ff(tx_out_ff), .gen_basic_ff(gen_basic_ff),
    .gen_crc_mf_ff(gen_crc_mf_ff), .gen_mod_crc_ff(gen_mod_crc_ff),
    .gen_sig_mf_ff(gen_sig_mf_ff), .irq_ff(irq_ff));
  eoh_line_model i_eoh_line_model (.hclk(hclk), .tx_out_ff(tx_out_ff),
    .sa6_word_vld(sa6_word_vld), .sa6_word(sa6_word),
    .e_bits_vld(e_bits_vld), .e_bits(e_bits), .rx_crc4_err(rx_crc4_err),
    .tx_in_vld(tx_in_vld), .tx_in(tx_in));
  // ----------
  // Tasks
  // ----------
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One AHB single transfer; waits on ready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h00_0000, i, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata_ff;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, {24'h00_0000, d});
  endtask
  task automatic rdc(input string n, input logic [7:0] i,
                     input logic [7:0] e);
    xfer(1'b0, i, 32'h0000_0000);
    chk(n, rv, {24'h00_0000, e});
    chk("hresp", 32'(hresp_ff), 32'h0000_0000);
  endtask
  // Read flags, then acknowledge them all
  task automatic fl(input logic [7:0] e);
    rdc("flags", eoh_pkg::IDX_OH_FLAGS, e);
    wr(eoh_pkg::IDX_OH_FLAGS, 8'h3F);
  endtask
  task automatic ir(input logic e);
    repeat (3) @(posedge hclk);
    chk("irq", 32'(irq_ff), 32'(e));
  endtask
  task automatic txc(input logic [7:0] md, input logic [3:0] f,
                     input logic [4:0] t, input logic [7:0] d, m, e);
    wr(eoh_pkg::IDX_TX_MODE, md);
    i_eoh_line_model.slot(f, t, d, q);
    chk("tx byte", 32'(q & m), 32'(e));
    chk("tx vld", 32'(tx_out_vld_ff), 32'h0000_0001);
  endtask
  task automatic gen(input logic [7:0] md, input logic [3:0] e);
    wr(eoh_pkg::IDX_TX_MODE, md);
    repeat (2) @(posedge hclk);
    chk("gen", 32'({gen_basic_ff, gen_crc_mf_ff, gen_mod_crc_ff,
                    gen_sig_mf_ff}), 32'(e));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("mode", eoh_pkg::IDX_TX_MODE, eoh_pkg::RST_MODE);
    rdc("intl", eoh_pkg::IDX_TX_INTL, eoh_pkg::RST_INTL);
    rdc("sa4", eoh_pkg::IDX_SA4_CW, eoh_pkg::RST_SA_CW);
    rdc("extra", eoh_pkg::IDX_TX_EXTRA, eoh_pkg::RST_EXTRA);
    rdc("irq en", eoh_pkg::IDX_OH_IRQ_EN, 8'h00);
    rdc("unmapped", 8'h70, 8'h00);
    fl(8'h00);
    // Codewords 0 to 3 cover none, far only, crc only and both
    for (int w = 0; w < 4; w++) begin
      i_eoh_line_model.rx_ev(0, 4'(w));
      fl({2'b00, w == 2 || w == 3, w == 1 || w == 3, 4'h0});
    end
    rdc("flags clear", eoh_pkg::IDX_OH_FLAGS, 8'h00);
    i_eoh_line_model.rx_ev(1, 4'h1);
    fl(8'h08);
    i_eoh_line_model.rx_ev(1, 4'h3);
    fl(8'h00);
    lost <= 1'b1;
    i_eoh_line_model.rx_ev(1, 4'h0);
    fl(8'h00);
    lost <= 1'b0;
    // Each status input rises then falls
    for (int i = 0; i < 3; i++) begin
      st[i] <= 1'b1;
      fl(8'(1 << i));
      st[i] <= 1'b0;
      fl(8'(1 << i));
    end
    wr(eoh_pkg::IDX_OH_IRQ_EN, 8'h01);
    st[0] <= 1'b1;
    ir(1'b1);
    wr(eoh_pkg::IDX_OH_IRQ_EN, 8'h3E);
    ir(1'b0);
    wr(eoh_pkg::IDX_OH_IRQ_EN, 8'h20);
    i_eoh_line_model.rx_ev(0, 4'h2);
    repeat (20) @(posedge hclk);
    ir(1'b1);
    wr(eoh_pkg::IDX_OH_FLAGS, 8'h20);
    ir(1'b0);
    fl(8'h01);
    // Transmit insertion, Si0 one and Si1 zero
    wr(eoh_pkg::IDX_TX_INTL, 8'h01);
    txc(8'h00, 4'h0, 5'h00, 8'h00, 8'h80, 8'h80);
    txc(8'h00, 4'h1, 5'h00, 8'hFF, 8'h80, 8'h00);
    txc(8'h20, 4'h0, 5'h00, 8'h00, 8'h80, 8'h00);
    txc(8'h01, 4'h0, 5'h00, 8'h00, 8'h80, 8'h00);
    wr(eoh_pkg::IDX_SA4_CW, 8'h05);
    wr(eoh_pkg::IDX_SA8_CW, 8'h0A);
    txc(8'h00, 4'h1, 5'h00, 8'hEE, 8'h11, 8'h00);
    wr(eoh_pkg::IDX_TX_NAT_EN, 8'h11);
    txc(8'h00, 4'h1, 5'h00, 8'hFF, 8'h11, 8'h01);
    txc(8'h02, 4'h3, 5'h00, 8'h00, 8'h11, 8'h10);
    wr(eoh_pkg::IDX_TX_MODE, 8'h02);
    i_eoh_line_model.rx_ev(2, 4'h0);
    txc(8'h02, 4'hD, 5'h00, 8'hFF, 8'h80, 8'h00);
    txc(8'h02, 4'hF, 5'h00, 8'h00, 8'h80, 8'h80);
    lost <= 1'b1;
    txc(8'h02, 4'hD, 5'h00, 8'h00, 8'h80, 8'h80);
    txc(8'h02, 4'hF, 5'h00, 8'hFF, 8'h80, 8'h00);
    lost <= 1'b0;
    txc(8'h12, 4'hD, 5'h00, 8'h00, 8'h80, 8'h80);
    txc(8'h32, 4'hD, 5'h00, 8'h00, 8'h80, 8'h00);
    txc(8'h32, 4'hF, 5'h00, 8'hFF, 8'h80, 8'h80);
    wr(eoh_pkg::IDX_TX_EXTRA, 8'h00);
    txc(8'h04, 4'h0, 5'h10, 8'hFF, 8'hFF, 8'hF4);
    txc(8'h44, 4'h0, 5'h10, 8'hFF, 8'hFF, 8'hFF);
    gen(8'h0A, 4'b1110);
    gen(8'h08, 4'b1000);
    gen(8'h04, 4'b1001);
    gen(8'h0F, 4'b0000);
    summarize();
  end
endmodule // test_e1_overhead_events_and_tx_insertion
`default_nettype wire
